//--- design/lse_pkg.sv
package lse_pkg;

    // slot timing: delays are programmed in microseconds
    localparam int CLK_PERIOD_NS = 4;
    localparam int DELAY_UNIT_NS = 1000;
    localparam int CYC_PER_US    = DELAY_UNIT_NS / CLK_PERIOD_NS;
    localparam int TIMER_W       = 24;

    localparam int NUM_SCHED = 4;
    localparam int NUM_ENTRY = 16;
    localparam int NUM_FRAME = 16;
    localparam int MAX_LIST  = 4;

    typedef enum logic [1:0] {
        ENT_UNCOND   = 2'h0,
        ENT_SPORADIC = 2'h1,
        ENT_EVENT    = 2'h2,
        ENT_NODECFG  = 2'h3
    } lse_kind_t;

    typedef enum logic [1:0] {
        POL_CONT = 2'h0,
        POL_ONCE = 2'h1,
        POL_NULL = 2'h2
    } lse_policy_t;

    // register byte offsets
    localparam logic [11:0] REG_REQ        = 12'h000;
    localparam logic [11:0] REG_IRQ_STATUS = 12'h004;
    localparam logic [11:0] REG_IRQ_MASK   = 12'h008;
    localparam logic [11:0] REG_UPDATE     = 12'h00c;
    localparam logic [11:0] REG_SCHED_BASE = 12'h010;
    localparam logic [11:0] REG_ENTRY_BASE = 12'h040;
    localparam logic [11:0] REG_ENTRY_END  = 12'h140;

    // schedule request / state word
    localparam int REQ_GO_BIT = 8;

    // schedule configuration fields
    localparam int SCFG_FIRST_LSB = 0;
    localparam int SCFG_LAST_LSB  = 4;
    localparam int SCFG_POL_LSB   = 8;
    localparam int SCFG_PRIO_LSB  = 16;
    localparam int SCFG_W         = 24;
    localparam logic [23:0] SCFG_RST = 24'h2a0000;

    // entry configuration fields
    localparam int ECFG_KIND_LSB = 0;
    localparam int ECFG_CNT_LSB  = 2;
    localparam int ECFG_FRM_LSB  = 4;
    localparam int ECFG_EVID_LSB = 20;
    localparam int ECFG_CRS_LSB  = 28;
    localparam int ECFG_CRS_VLD  = 30;
    localparam int ECFG_W        = 31;

    // interrupt status bits
    localparam int IRQ_COLL = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_SLOT = 2;
    localparam int IRQ_W    = 3;

endpackage : lse_pkg

//--- design/lse_slot_timer.sv
module lse_slot_timer (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // control
    input  wire logic        load_i,
    input  wire logic [15:0] delay_us_i,
    // status
    output logic             zero_o
);

    logic [lse_pkg::TIMER_W-1:0] cnt;
    logic [15:0]                 us;

    // a zero delay is stretched to one microsecond so a slot never collapses
    assign us = (delay_us_i == 16'h0000) ? 16'h0001 : delay_us_i;

    // two cycles are spent on the boundary decision and the issue cycle
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cnt <= '0;
        end else if (load_i) begin
            cnt <= lse_pkg::TIMER_W'(32'(us) * lse_pkg::CYC_PER_US - 2);
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end
    end

    assign zero_o = (cnt == '0);

endmodule : lse_slot_timer

//--- design/lse_pid_gen.sv
module lse_pid_gen (
    // identifier in, protected identifier out
    input  wire logic [5:0] id_i,
    output logic      [7:0] pid_o
);

    assign pid_o = {~(id_i[1] ^ id_i[3] ^ id_i[4] ^ id_i[5]),
                    id_i[0] ^ id_i[1] ^ id_i[2] ^ id_i[4],
                    id_i};

endmodule : lse_pid_gen

//--- design/lse_executor.sv
// Contract
// - entry kind 0 unconditional, 1 sporadic, 2 event, 3 node configuration
// - unconditional slot sends exactly the single listed frame
// - sporadic slot sends first updated frame in list; others stay pending
// - collision runs resolving table once next slot, then resumes at that entry
// - resolving request is raised by the device itself, no software needed
// - resolving reference reads empty and invalid unless entry is event kind
// - event identifier held unprotected; device adds parity bits
// - node config entry holds 8 raw bytes, sent only for that kind
// - delay runs from start of one entry to start of the next
// - one frame may be referenced by many entries and schedules
// - continuous schedule wraps to its first entry after its last
// - run-once schedule ends by taking next pending run-once, else returning to interrupted or continuous schedule, or idle
// - pending run-once served lowest priority value first, before continuous
// - null request stops at once and drops all pending run-once requests
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
module lse_executor (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // ahb-lite slave
    input  wire logic        HSEL_I,
    input  wire logic [11:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // link framer side
    input  wire logic        COLLISION_I,
    output logic             SLOT_REQ_O,
    output logic      [1:0]  SLOT_KIND_O,
    output logic      [3:0]  SLOT_FRAME_O,
    output logic      [7:0]  SLOT_PID_O,
    output logic      [63:0] SLOT_DATA_O,
    // interrupt
    output logic             IRQ_O
);

    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} lse_state_t;

    lse_state_t state;
    logic [lse_pkg::SCFG_W-1:0] sched_cfg [lse_pkg::NUM_SCHED];
    logic [lse_pkg::ECFG_W-1:0] ent_cfg   [lse_pkg::NUM_ENTRY];
    logic [15:0]                ent_dly   [lse_pkg::NUM_ENTRY];
    logic [63:0]                ent_nc    [lse_pkg::NUM_ENTRY];
    logic [lse_pkg::NUM_FRAME-1:0] frame_pend;
    logic [lse_pkg::IRQ_W-1:0]  irq_status;
    logic [lse_pkg::IRQ_W-1:0]  irq_mask;

    // bus data phase
    logic        wr_pend;
    logic [11:0] wr_addr;
    logic [11:0] ent_off;
    logic        wr_ent;
    logic        wr_sched;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else if (HREADY_I) begin
            wr_pend <= HSEL_I && HTRANS_I[1] && HWRITE_I;
            wr_addr <= {HADDR_I[11:2], 2'b00};
        end
    end

    assign ent_off  = wr_addr - lse_pkg::REG_ENTRY_BASE;
    assign wr_ent   = wr_pend && wr_addr >= lse_pkg::REG_ENTRY_BASE
                      && wr_addr < lse_pkg::REG_ENTRY_END;
    assign wr_sched = wr_pend && wr_addr >= lse_pkg::REG_SCHED_BASE
                      && wr_addr < lse_pkg::REG_ENTRY_BASE;

    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;

    // configuration storage; a frame number may appear in any entry
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int i = 0; i < lse_pkg::NUM_SCHED; i++) begin
                sched_cfg[i] <= lse_pkg::SCFG_RST;
            end
            for (int i = 0; i < lse_pkg::NUM_ENTRY; i++) begin
                ent_cfg[i] <= '0;
                ent_dly[i] <= 16'h0000;
                ent_nc[i]  <= 64'h0;
            end
        end else if (wr_sched) begin
            sched_cfg[wr_addr[3:2]] <= HWDATA_I[lse_pkg::SCFG_W-1:0];
        end else if (wr_ent) begin
            case (ent_off[3:2])
                2'h0: ent_cfg[ent_off[7:4]] <= HWDATA_I[lse_pkg::ECFG_W-1:0];
                2'h1: ent_dly[ent_off[7:4]] <= HWDATA_I[15:0];
                2'h2: ent_nc[ent_off[7:4]][31:0] <= HWDATA_I;
                default: ent_nc[ent_off[7:4]][63:32] <= HWDATA_I;
            endcase
        end
    end

    // current entry decode
    logic [1:0]  cur_sched;
    logic [3:0]  cur_pos;
    logic        cur_once;
    logic [lse_pkg::ECFG_W-1:0] cur_cfg;
    lse_pkg::lse_kind_t cur_kind;
    logic [1:0]  cur_cnt;
    logic [1:0]  cur_crs;
    logic        cur_crs_vld;
    logic [5:0]  cur_evid;
    logic [7:0]  cur_pid;

    assign cur_cfg     = ent_cfg[cur_pos];
    assign cur_kind    = lse_pkg::lse_kind_t'(cur_cfg[lse_pkg::ECFG_KIND_LSB +: 2]);
    assign cur_cnt     = cur_cfg[lse_pkg::ECFG_CNT_LSB +: 2];
    assign cur_crs     = cur_cfg[lse_pkg::ECFG_CRS_LSB +: 2];
    assign cur_crs_vld = cur_cfg[lse_pkg::ECFG_CRS_VLD] && cur_kind == lse_pkg::ENT_EVENT;
    assign cur_evid    = cur_cfg[lse_pkg::ECFG_EVID_LSB +: 6];

    lse_pid_gen u_pid (
        .id_i  (cur_evid),
        .pid_o (cur_pid)
    );

    // sporadic pick: earliest updated frame of the list wins
    logic       spor_ok;
    logic [3:0] spor_frame;

    always_comb begin
        spor_ok    = 1'b0;
        spor_frame = cur_cfg[lse_pkg::ECFG_FRM_LSB +: 4];
        for (int i = lse_pkg::MAX_LIST - 1; i >= 0; i--) begin
            if (i <= int'(cur_cnt)
                && frame_pend[cur_cfg[lse_pkg::ECFG_FRM_LSB + 4*i +: 4]]) begin
                spor_ok    = 1'b1;
                spor_frame = cur_cfg[lse_pkg::ECFG_FRM_LSB + 4*i +: 4];
            end
        end
    end

    // schedule bookkeeping
    logic [lse_pkg::NUM_SCHED-1:0] pend_once;
    logic       cont_valid;
    logic [1:0] cont_sched;
    logic       ret_valid;
    logic [1:0] ret_sched;
    logic [3:0] ret_pos;
    logic       ret_once;
    logic       coll_pend;
    logic [1:0] coll_sched;
    logic [3:0] coll_pos;

    logic       req_wr;
    logic [1:0] req_sched;
    lse_pkg::lse_policy_t req_pol;
    logic       null_req;

    assign req_wr    = wr_pend && wr_addr == lse_pkg::REG_REQ && HWDATA_I[lse_pkg::REQ_GO_BIT];
    assign req_sched = HWDATA_I[1:0];
    assign req_pol   = lse_pkg::lse_policy_t'(sched_cfg[req_sched][lse_pkg::SCFG_POL_LSB +: 2]);
    assign null_req  = req_wr && req_pol == lse_pkg::POL_NULL;

    function automatic logic [3:0] first_of(input logic [lse_pkg::SCFG_W-1:0] c);
        return c[lse_pkg::SCFG_FIRST_LSB +: 4];
    endfunction : first_of

    // lowest priority value among pending run-once requests
    logic       best_ok;
    logic [1:0] best;
    logic [7:0] best_prio;

    always_comb begin
        best_ok   = 1'b0;
        best      = 2'h0;
        best_prio = 8'hff;
        for (int i = 0; i < lse_pkg::NUM_SCHED; i++) begin
            if (pend_once[i] && (!best_ok
                || sched_cfg[i][lse_pkg::SCFG_PRIO_LSB +: 8] < best_prio)) begin
                best_ok   = 1'b1;
                best      = 2'(i);
                best_prio = sched_cfg[i][lse_pkg::SCFG_PRIO_LSB +: 8];
            end
        end
    end

    logic timer_zero;
    logic coll_now;
    logic coll_any;
    logic boundary;
    logic at_last;

    // the framer reports the collision; no software step is involved
    assign coll_now = state == ST_WAIT && COLLISION_I && cur_crs_vld;
    assign coll_any = coll_pend || coll_now;
    assign boundary = state == ST_IDLE || (state == ST_WAIT && timer_zero);
    assign at_last  = cur_pos == sched_cfg[cur_sched][lse_pkg::SCFG_LAST_LSB +: 4];

    // decision taken at every slot boundary
    logic       next_run;
    logic [1:0] next_sched;
    logic [3:0] next_pos;
    logic       next_once;
    logic       take_best;
    logic       save_ret;
    logic       use_ret;
    logic       take_coll;
    logic       once_done;

    always_comb begin
        next_run   = 1'b1;
        next_sched = cur_sched;
        next_pos   = cur_pos + 4'h1;
        next_once  = cur_once;
        take_best  = 1'b0;
        save_ret   = 1'b0;
        use_ret    = 1'b0;
        take_coll  = 1'b0;
        once_done  = 1'b0;
        if (state != ST_IDLE && coll_any) begin
            take_coll  = 1'b1;
            next_sched = coll_pend ? coll_sched : cur_crs;
            next_pos   = first_of(sched_cfg[next_sched]);
            next_once  = 1'b1;
        end else if (state != ST_IDLE && cur_once && !at_last) begin
            next_once = 1'b1;
        end else if (state != ST_IDLE && !cur_once && best_ok) begin
            save_ret = 1'b1;
            take_best = 1'b1;
        end else if (state != ST_IDLE && cur_once) begin
            once_done = 1'b1;
            if (best_ok) begin
                take_best = 1'b1;
            end else if (ret_valid) begin
                use_ret    = 1'b1;
                next_sched = ret_sched;
                next_pos   = ret_pos;
                next_once  = ret_once;
            end else if (cont_valid) begin
                next_sched = cont_sched;
                next_pos   = first_of(sched_cfg[cont_sched]);
                next_once  = 1'b0;
            end else begin
                next_run = 1'b0;
            end
        end else if (state != ST_IDLE && cont_valid && cur_sched == cont_sched && !at_last) begin
            next_once = 1'b0;
        end else if (best_ok) begin
            take_best = 1'b1;
        end else if (cont_valid) begin
            next_sched = cont_sched;
            next_pos   = first_of(sched_cfg[cont_sched]);
            next_once  = 1'b0;
        end else begin
            next_run = 1'b0;
        end
        if (take_best) begin
            next_sched = best;
            next_pos   = first_of(sched_cfg[best]);
            next_once  = 1'b1;
        end
    end

    // scheduler state
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state      <= ST_IDLE;
            cur_sched  <= 2'h0;
            cur_pos    <= 4'h0;
            cur_once   <= 1'b0;
            pend_once  <= '0;
            cont_valid <= 1'b0;
            cont_sched <= 2'h0;
            ret_valid  <= 1'b0;
            ret_sched  <= 2'h0;
            ret_pos    <= 4'h0;
            ret_once   <= 1'b0;
            coll_pend  <= 1'b0;
            coll_sched <= 2'h0;
            coll_pos   <= 4'h0;
        end else if (null_req) begin
            state      <= ST_IDLE;
            pend_once  <= '0;
            cont_valid <= 1'b0;
            ret_valid  <= 1'b0;
            coll_pend  <= 1'b0;
        end else begin
            if (state == ST_ISSUE) begin
                state <= ST_WAIT;
            end else if (boundary && (next_run || state != ST_IDLE)) begin
                state     <= next_run ? ST_ISSUE : ST_IDLE;
                cur_sched <= next_sched;
                cur_pos   <= next_pos;
                cur_once  <= next_once;
            end
            if (coll_now && !timer_zero) begin
                coll_pend  <= 1'b1;
                coll_sched <= cur_crs;
                coll_pos   <= cur_pos;
            end else if (boundary && take_coll) begin
                coll_pend <= 1'b0;
            end
            if (boundary && take_coll) begin
                ret_valid <= 1'b1;
                ret_sched <= cur_sched;
                ret_pos   <= coll_pend ? coll_pos : cur_pos;
                ret_once  <= cur_once;
            end else if (boundary && save_ret) begin
                ret_valid <= 1'b1;
                ret_sched <= cur_sched;
                ret_pos   <= at_last ? first_of(sched_cfg[cur_sched]) : cur_pos + 4'h1;
                ret_once  <= 1'b0;
            end else if (boundary && use_ret) begin
                ret_valid <= 1'b0;
            end
            // a request arriving as its bit is taken keeps it pending
            for (int i = 0; i < lse_pkg::NUM_SCHED; i++) begin
                if (req_wr && req_pol == lse_pkg::POL_ONCE && req_sched == 2'(i)) begin
                    pend_once[i] <= 1'b1;
                end else if (boundary && take_best && best == 2'(i)) begin
                    pend_once[i] <= 1'b0;
                end
            end
            if (req_wr && req_pol == lse_pkg::POL_CONT) begin
                cont_valid <= 1'b1;
                cont_sched <= req_sched;
            end
        end
    end

    lse_slot_timer u_timer (
        .CLK_I      (CLK_I),
        .RST_I      (RST_I),
        .load_i     (state == ST_ISSUE),
        .delay_us_i (ent_dly[cur_pos]),
        .zero_o     (timer_zero)
    );

    // slot action toward the framer
    logic issue;
    assign issue = state == ST_ISSUE && !null_req;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            SLOT_REQ_O   <= 1'b0;
            SLOT_KIND_O  <= 2'h0;
            SLOT_FRAME_O <= 4'h0;
            SLOT_PID_O   <= 8'h00;
            SLOT_DATA_O  <= 64'h0;
        end else begin
            SLOT_REQ_O <= issue && (cur_kind != lse_pkg::ENT_SPORADIC || spor_ok);
            if (issue) begin
                SLOT_KIND_O  <= cur_kind;
                SLOT_FRAME_O <= (cur_kind == lse_pkg::ENT_SPORADIC) ? spor_frame
                                : cur_cfg[lse_pkg::ECFG_FRM_LSB +: 4];
                // slaves fill the event slot themselves; only the header is ours
                SLOT_PID_O   <= (cur_kind == lse_pkg::ENT_EVENT) ? cur_pid : 8'h00;
                SLOT_DATA_O  <= (cur_kind == lse_pkg::ENT_NODECFG) ? ent_nc[cur_pos]
                                : 64'h0;
            end
        end
    end

    // frame update flags: software sets, a sporadic send clears, set wins
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            frame_pend <= '0;
        end else begin
            for (int f = 0; f < lse_pkg::NUM_FRAME; f++) begin
                if (wr_pend && wr_addr == lse_pkg::REG_UPDATE && HWDATA_I[f]) begin
                    frame_pend[f] <= 1'b1;
                end else if (issue && cur_kind == lse_pkg::ENT_SPORADIC && spor_ok
                             && spor_frame == 4'(f)) begin
                    frame_pend[f] <= 1'b0;
                end
            end
        end
    end

    // interrupts
    logic [lse_pkg::IRQ_W-1:0] irq_set;
    assign irq_set = {issue, boundary && once_done, coll_now};

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_status <= '0;
            irq_mask   <= '0;
        end else begin
            if (wr_pend && wr_addr == lse_pkg::REG_IRQ_MASK) begin
                irq_mask <= HWDATA_I[lse_pkg::IRQ_W-1:0];
            end
            if (wr_pend && wr_addr == lse_pkg::REG_IRQ_STATUS) begin
                irq_status <= (irq_status & ~HWDATA_I[lse_pkg::IRQ_W-1:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
        end
    end

    assign IRQ_O = |(irq_status & irq_mask);

    // read data is prepared in the address phase
    logic [11:0] rd_off;
    logic [31:0] rd_val;
    localparam int ECFG_W_T = lse_pkg::ECFG_W;
    logic [ECFG_W_T-1:0] rd_cfg;

    assign rd_off = {HADDR_I[11:2], 2'b00} - lse_pkg::REG_ENTRY_BASE;
    assign rd_cfg = ent_cfg[rd_off[7:4]];

    always_comb begin
        rd_val = 32'h0;
        if ({HADDR_I[11:2], 2'b00} == lse_pkg::REG_REQ) begin
            rd_val = {11'h0, cont_valid, cur_pos, 4'h0, pend_once,
                      2'h0, cur_once, state != ST_IDLE, 2'h0, cur_sched};
        end else if ({HADDR_I[11:2], 2'b00} == lse_pkg::REG_IRQ_STATUS) begin
            rd_val = 32'(irq_status);
        end else if ({HADDR_I[11:2], 2'b00} == lse_pkg::REG_IRQ_MASK) begin
            rd_val = 32'(irq_mask);
        end else if ({HADDR_I[11:2], 2'b00} == lse_pkg::REG_UPDATE) begin
            rd_val = 32'(frame_pend);
        end else if (HADDR_I >= lse_pkg::REG_SCHED_BASE && HADDR_I < lse_pkg::REG_ENTRY_BASE) begin
            rd_val = 32'(sched_cfg[HADDR_I[3:2]]);
        end else if (HADDR_I >= lse_pkg::REG_ENTRY_BASE && HADDR_I < lse_pkg::REG_ENTRY_END) begin
            case (rd_off[3:2])
                2'h0: begin
                    rd_val = 32'(rd_cfg);
                    if (rd_cfg[lse_pkg::ECFG_KIND_LSB +: 2] != lse_pkg::ENT_EVENT) begin
                        rd_val[lse_pkg::ECFG_CRS_VLD:lse_pkg::ECFG_CRS_LSB] = 3'h0;
                    end
                end
                2'h1: rd_val = 32'(ent_dly[rd_off[7:4]]);
                2'h2: rd_val = ent_nc[rd_off[7:4]][31:0];
                default: rd_val = ent_nc[rd_off[7:4]][63:32];
            endcase
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            HRDATA_O <= 32'h0;
        end else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
            HRDATA_O <= rd_val;
        end
    end

endmodule : lse_executor

//--- bench/lse_props.sv
module lse_props (
    // clock and reset
    input wire logic        CLK_I,
    input wire logic        RST_I,
    // bus
    input wire logic        HSEL_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    // slot side
    input wire logic        SLOT_REQ_O,
    input wire logic [1:0]  SLOT_KIND_O,
    input wire logic [3:0]  SLOT_FRAME_O,
    input wire logic [7:0]  SLOT_PID_O,
    input wire logic [63:0] SLOT_DATA_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic rd_go;
    logic [77:0] fields;
    assign rd_go = HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
    assign fields = {SLOT_KIND_O, SLOT_FRAME_O, SLOT_PID_O, SLOT_DATA_O};
    sequence ev_slot;
        SLOT_REQ_O && SLOT_KIND_O == lse_pkg::ENT_EVENT;
    endsequence
    zero_wait_a: assert property (HREADYOUT_O) else $error("wait state seen");
    resp_okay_a: assert property (!HRESP_O) else $error("error response");
    rdata_hold_a: assert property (!rd_go |=> $stable(HRDATA_O)) else $error("rdata moved");
    pid_parity_a: assert property (ev_slot |-> SLOT_PID_O[6] == ^{SLOT_PID_O[4],
        SLOT_PID_O[2:0]} && SLOT_PID_O[7] == ~^{SLOT_PID_O[5:3], SLOT_PID_O[1]})
        else $error("bad parity");
    pid_clear_a: assert property (SLOT_REQ_O && SLOT_KIND_O != lse_pkg::ENT_EVENT
        |-> SLOT_PID_O == 8'h00) else $error("pid outside event slot");
    data_clear_a: assert property (SLOT_REQ_O && SLOT_KIND_O != lse_pkg::ENT_NODECFG
        |-> SLOT_DATA_O == 64'h0) else $error("raw bytes outside config slot");
    req_pulse_a: assert property (SLOT_REQ_O |=> !SLOT_REQ_O [*8])
        else $error("slot too soon");
    field_hold_a: assert property (!SLOT_REQ_O |-> $stable(fields))
        else $error("fields moved");
endmodule : lse_props

bind lse_executor lse_props u_lse_props (.CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .SLOT_REQ_O(SLOT_REQ_O),
    .SLOT_KIND_O(SLOT_KIND_O), .SLOT_FRAME_O(SLOT_FRAME_O), .SLOT_PID_O(SLOT_PID_O),
    .SLOT_DATA_O(SLOT_DATA_O));

//--- bench/lse_slave_model.sv
module lse_slave_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // slot side
    input  wire logic       slot_req_i,
    input  wire logic [1:0] slot_kind_i,
    input  wire logic       collide_i,
    output logic            collision_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // two updated slaves answer together only when told to
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            cnt <= 4'h0;
        else if (slot_req_i && slot_kind_i == 2'h2 && collide_i)
            cnt <= 4'h5;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
    assign collision_o = (cnt == 4'h1);
endmodule : lse_slave_model

//--- bench/lin_schedule_entry_executor_tb.sv
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("mismatch %0t: got %h want %h", $time, a, e); end end
module lin_schedule_entry_executor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] RAW = 64'h0807060504030201;
    localparam int C = lse_pkg::CYC_PER_US;
    typedef struct {
        logic [31:0] cfg; logic [15:0] upd; logic [1:0] k;
        logic [3:0] f; logic [7:0] p; logic [15:0] pn;
    } lse_row_t;
    lse_row_t rows [4] = '{'{32'h5000_0050, 16'h0, 2'h0, 4'h5, 8'h00, 16'h0},
        '{32'h5010_0062, 16'h0, 2'h2, 4'h6, 8'hc1, 16'h0},
        '{32'h5000_0003, 16'h0, 2'h3, 4'h0, 8'h00, 16'h0},
        '{32'h5000_9739, 16'h0280, 2'h1, 4'h7, 8'h00, 16'h0200}};
    logic [1:0] ek [6] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0};
    logic [3:0] ef [6] = '{4'h1, 4'h2, 4'h6, 4'h4, 4'h6, 4'h1};
    int gp [6] = '{0, 2 * C, C, C, C, C};
    logic        clk, rst, hsel, hwrite, coll, coll_en, req, irq, rdy_o;
    logic [1:0]  htrans, kind;
    logic [11:0] haddr;
    logic [31:0] hwdata, hrdata, rd;
    logic [3:0]  frm;
    logic [7:0]  pid;
    logic [63:0] data;
    int          n_mismatch = 0, check_count = 0, cyc, k;

    lse_executor u_lse_executor (.CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(rdy_o), .HRDATA_O(hrdata), .HREADYOUT_O(rdy_o), .HRESP_O(),
        .COLLISION_I(coll), .SLOT_REQ_O(req), .SLOT_KIND_O(kind), .SLOT_FRAME_O(frm),
        .SLOT_PID_O(pid), .SLOT_DATA_O(data), .IRQ_O(irq));
    lse_slave_model u_lse_slave_model (.clk_i(clk), .rst_i(rst), .slot_req_i(req),
        .slot_kind_i(kind), .collide_i(coll_en), .collision_o(coll));

    task automatic finish_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (rdy_o !== 1'b1) begin
            n++;
            if (n > 50) begin n_mismatch++; finish_test(); end
            @(posedge clk);
        end
    endtask : rdy
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        rdy();
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        rdy();
        rd = hrdata;
    endtask : bus
    // bounded wait for the next slot, counting cycles since the last one
    task automatic wslot();
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
            if (cyc > 2000) begin n_mismatch++; finish_test(); end
        end while (req !== 1'b1);
    endtask : wslot
    task automatic quiet(input int n);
        k = 0;
        repeat (n) begin @(negedge clk); if (req === 1'b1) k++; end
        `CHK(k, 0)
    endtask : quiet

    initial begin clk = 1'b0; forever #2 clk = ~clk; end
    initial begin
        rst = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = 12'h0; hwrite = 1'b0;
        hwdata = 32'h0; coll_en = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(0, 12'h010, 0); `CHK(rd, 32'h002a_0000)
        // unmapped place: write dropped, reads zero
        bus(1, 12'h300, 32'hffff_ffff); bus(0, 12'h300, 0); `CHK(rd, 32'h0)
        bus(1, 12'h048, RAW[31:0]); bus(1, 12'h04c, RAW[63:32]); bus(1, 12'h044, 1);
        foreach (rows[i]) begin
            bus(1, 12'h040, rows[i].cfg); bus(1, 12'h00c, {16'h0, rows[i].upd});
            bus(1, 12'h010, 32'h002a_0100); bus(1, 12'h000, 32'h100);
            wslot();
            `CHK(kind, rows[i].k)
            `CHK(frm, rows[i].f)
            `CHK(pid, rows[i].p)
            `CHK(data, rows[i].k == 2'h3 ? RAW : 64'h0)
            bus(0, 12'h040, 0);
            `CHK(rd, rows[i].k == 2'h2 ? rows[i].cfg : rows[i].cfg & 32'h8fff_ffff)
            bus(0, 12'h00c, 0); `CHK(rd[15:0], rows[i].pn)
            quiet(300);
        end
        bus(1, 12'h050, 32'h10); bus(1, 12'h054, 2); bus(1, 12'h060, 32'h20);
        bus(1, 12'h064, 1); bus(1, 12'h070, 32'h6010_0062); bus(1, 12'h074, 1);
        bus(1, 12'h080, 32'h40); bus(1, 12'h084, 1);
        bus(1, 12'h014, 32'h002a_0031); bus(1, 12'h018, 32'h002a_0144);
        `CHK(irq, 1'b0)
        bus(1, 12'h008, 1);
        coll_en <= 1'b1;
        bus(1, 12'h000, 32'h101);
        for (int i = 0; i < 6; i++) begin
            wslot();
            if (i > 0) `CHK(cyc, gp[i])
            `CHK(kind, ek[i])
            `CHK(frm, ef[i])
            // the slaves see the event slot one edge after it is seen here
            if (i == 3) coll_en <= 1'b0;
        end
        `CHK(irq, 1'b1)
        bus(0, 12'h004, 0); `CHK(rd[0], 1'b1)
        bus(1, 12'h004, 1);
        @(negedge clk);
        `CHK(irq, 1'b0)
        bus(1, 12'h01c, 32'h0200); bus(1, 12'h000, 32'h103);
        quiet(600);
        finish_test();
    end
endmodule : lin_schedule_entry_executor_tb
